//--- design/pad_cell_pkg.sv
/*
 * Shared constants and mode types for the configurable pad cell.
 * Assumes: included before the store interface and both design modules.
 */
package pad_cell_pkg;

    // Storage element slots inside one pad cell
    localparam int NUM_ELEMS = 3;
    localparam int ELEM_IN = 0;
    localparam int ELEM_OUT = 1;
    localparam int ELEM_OE = 2;

    // Value every storage element and sampler holds after reset
    localparam logic Q_RESET = 1'h0;

    // How an element reacts to the shared set/reset line
    typedef enum logic [1:0] {
        SR_SYNC_SET,
        SR_SYNC_RESET,
        SR_ASYNC_PRESET,
        SR_ASYNC_CLEAR
    } sr_mode_t;

    // Resistor choice once configuration is done
    typedef enum logic [1:0] {
        PULL_NONE,
        PULL_UP,
        PULL_DOWN
    } pull_t;

endpackage : pad_cell_pkg

//--- design/store_if.sv
/*
 * Link between the pad cell top and one of its storage elements.
 * Assumes: the top drives data, enable and mode; the element returns q.
 */
`timescale 1ns/1ps
interface store_if;
    logic d;
    logic ce;
    logic latch;
    pad_cell_pkg::sr_mode_t mode;
    logic q;

    modport owner (output d, output ce, output latch, output mode, input q);
    modport elem (input d, input ce, input latch, input mode, output q);
endinterface : store_if

//--- design/store_elem.sv
/*
 * One pad cell storage element: flip-flop or transparent latch with
 * a configurable sync/async set/reset.
 * Assumes: cell clock, enable and set/reset already polarity-corrected and
 * synchronous to mclk_i; the cell clock is sampled, so its edges are seen
 * one mclk_i cycle late.
 */
`timescale 1ns/1ps
module store_elem (
    // System
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Shared cell controls
    input wire logic cell_clk_i,
    input wire logic set_reset_i,
    // Element data and config
    store_if.elem bus
);
    typedef struct packed {
        logic q;
        logic clk_prev;
    } elem_state_t;

    elem_state_t st_reg;
    elem_state_t st_next;
    logic sr_async;
    logic sr_val;
    logic edge_seen;
    logic transparent;

    always_comb begin
        sr_async = set_reset_i && (bus.mode == pad_cell_pkg::SR_ASYNC_PRESET ||
                                   bus.mode == pad_cell_pkg::SR_ASYNC_CLEAR);
        sr_val = (bus.mode == pad_cell_pkg::SR_SYNC_SET || bus.mode == pad_cell_pkg::SR_ASYNC_PRESET);
        edge_seen = cell_clk_i && !st_reg.clk_prev;
        transparent = bus.latch && cell_clk_i && bus.ce;
        st_next = st_reg;
        st_next.clk_prev = cell_clk_i;
        if (sr_async) begin
            st_next.q = sr_val;
        end else if (bus.latch) begin
            if (transparent) begin
                st_next.q = set_reset_i ? sr_val : bus.d;
            end
        end else if (edge_seen) begin
            // Sync set/reset outranks the clock enable
            if (set_reset_i) begin
                st_next.q = sr_val;
            end else if (bus.ce) begin
                st_next.q = bus.d;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '{q: pad_cell_pkg::Q_RESET, clk_prev: 1'h0};
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    // Async force and open latch show at once, not a cycle later
    assign bus.q = sr_async ? sr_val : (transparent ? (set_reset_i ? sr_val : bus.d) : st_reg.q);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    flop_capture_a: assert property (clk_en_i && !bus.latch && edge_seen && bus.ce && !set_reset_i
        |=> bus.q == $past(bus.d) || set_reset_i || transparent)
        else $error("flip-flop did not capture data on enabled edge");
    async_clear_a: assert property (set_reset_i && bus.mode == pad_cell_pkg::SR_ASYNC_CLEAR
        |-> bus.q == 1'h0)
        else $error("asynchronous clear not seen on element output");
    latch_hold_a: assert property (clk_en_i && bus.latch && !cell_clk_i && !set_reset_i
        ##1 (!cell_clk_i && !set_reset_i) |-> bus.q == $past(bus.q))
        else $error("closed latch changed its value");
endmodule : store_elem

//--- design/pad_cell.sv
/*
 * Configurable pad cell: input capture, output data and output enable
 * storage, bypass paths, control polarity, pulls and weak keeper.
 * Assumes: all inputs synchronous to mclk_i; pad wire resolved outside
 * from pad_o/pad_oe_o, pulls and keeper drive.
 */
// What this block does
// - Each of three storage elements is a flip-flop or a latch.
// - One shared cell clock; each element has its own clock enable.
// - Shared set/reset: per element sync set, sync reset, async preset, async clear.
// - Output drive, clock, enables and set/reset each have polarity inversion.
// - Before configuration: pad undriven, pull-down and keeper off.
// - Pre-configuration pull-ups follow the global mode input, else pad floats.
// - Received value reaches logic directly or via the input element.
// - Optional delay stage in front of input element data.
// - Pad data comes directly from logic or from output element.
// - Output enable comes directly or from its own element.
// - After configuration, keeper weakly drives last sensed level while pad undriven.
// - After configuration, per-pad pull-up or pull-down selectable.
`timescale 1ns/1ps
module pad_cell (
    // System
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Configuration state
    input wire logic config_done_i,
    input wire logic pullup_mode_i,
    // Fabric side
    input wire logic out_data_i,
    input wire logic out_enable_i,
    output logic in_data_o,
    // Shared cell controls
    input wire logic cell_clk_i,
    input wire logic [2:0] elem_ce_i,
    input wire logic shared_set_reset_i,
    // Element setup
    input wire logic [2:0] latch_sel_i,
    input wire pad_cell_pkg::sr_mode_t sr_mode_in_i,
    input wire pad_cell_pkg::sr_mode_t sr_mode_out_i,
    input wire pad_cell_pkg::sr_mode_t sr_mode_oe_i,
    // Polarity setup
    input wire logic inv_clk_i,
    input wire logic [2:0] inv_ce_i,
    input wire logic inv_sr_i,
    input wire logic inv_out_i,
    // Path setup
    input wire logic in_reg_sel_i,
    input wire logic in_delay_sel_i,
    input wire logic out_reg_sel_i,
    input wire logic oe_reg_sel_i,
    input wire logic keeper_sel_i,
    input wire pad_cell_pkg::pull_t pull_sel_i,
    // Pad side
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe_o,
    output logic pull_up_o,
    output logic pull_down_o,
    output logic keeper_o,
    output logic keeper_oe_o
);
    typedef struct packed {
        logic sensed;
        logic delayed;
    } cell_state_t;

    cell_state_t st_reg;
    cell_state_t st_next;
    logic clk_pol;
    logic sr_pol;
    logic [2:0] ce_pol;
    logic out_val;
    logic oe_val;
    pad_cell_pkg::sr_mode_t modes [pad_cell_pkg::NUM_ELEMS];
    logic [2:0] elem_d;

    store_if elem_bus [pad_cell_pkg::NUM_ELEMS] ();

    // Control polarity applied once; clock and set/reset inversion shared by all elements, enable inversion per element
    assign clk_pol = cell_clk_i ^ inv_clk_i;
    assign sr_pol = shared_set_reset_i ^ inv_sr_i;
    assign ce_pol = elem_ce_i ^ inv_ce_i;

    assign modes[pad_cell_pkg::ELEM_IN] = sr_mode_in_i;
    assign modes[pad_cell_pkg::ELEM_OUT] = sr_mode_out_i;
    assign modes[pad_cell_pkg::ELEM_OE] = sr_mode_oe_i;

    // Delayed copy offsets the sampled-clock lag, keeping capture hold-free
    assign elem_d[pad_cell_pkg::ELEM_IN] = in_delay_sel_i ? st_reg.delayed : pad_i;
    assign elem_d[pad_cell_pkg::ELEM_OUT] = out_data_i;
    assign elem_d[pad_cell_pkg::ELEM_OE] = out_enable_i;

    for (genvar g = 0; g < pad_cell_pkg::NUM_ELEMS; g++) begin : g_elem
        assign elem_bus[g].d = elem_d[g];
        assign elem_bus[g].ce = ce_pol[g];
        assign elem_bus[g].latch = latch_sel_i[g];
        assign elem_bus[g].mode = modes[g];
        store_elem u_elem (
            .mclk_i(mclk_i),
            .reset_i(reset_i),
            .clk_en_i(clk_en_i),
            .cell_clk_i(clk_pol),
            .set_reset_i(sr_pol),
            .bus(elem_bus[g])
        );
    end

    always_comb begin
        st_next = st_reg;
        st_next.sensed = pad_i;
        st_next.delayed = pad_i;
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '{sensed: pad_cell_pkg::Q_RESET, delayed: pad_cell_pkg::Q_RESET};
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    assign in_data_o = in_reg_sel_i ? elem_bus[pad_cell_pkg::ELEM_IN].q : pad_i;
    assign out_val = out_reg_sel_i ? elem_bus[pad_cell_pkg::ELEM_OUT].q : out_data_i;
    assign oe_val = oe_reg_sel_i ? elem_bus[pad_cell_pkg::ELEM_OE].q : out_enable_i;

    assign pad_o = out_val ^ inv_out_i;
    // Driver held off until configuration completes
    assign pad_oe_o = config_done_i && oe_val;
    // Keeper only fills in while nobody here drives the pad
    assign keeper_o = st_reg.sensed;
    assign keeper_oe_o = config_done_i && keeper_sel_i && !oe_val;
    assign pull_up_o = config_done_i ? (pull_sel_i == pad_cell_pkg::PULL_UP) : pullup_mode_i;
    assign pull_down_o = config_done_i && (pull_sel_i == pad_cell_pkg::PULL_DOWN);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    preconfig_quiet_a: assert property (!config_done_i
        |-> !pad_oe_o && !keeper_oe_o && !pull_down_o)
        else $error("pad active before configuration");
    preconfig_pullup_a: assert property (!config_done_i |-> pull_up_o == pullup_mode_i)
        else $error("pre-configuration pull-up does not follow mode input");
    input_bypass_a: assert property (!in_reg_sel_i |-> in_data_o == pad_i)
        else $error("input bypass does not pass the pad value");
    delay_stage_a: assert property (clk_en_i && in_delay_sel_i ##1 in_delay_sel_i
        |-> elem_bus[pad_cell_pkg::ELEM_IN].d == $past(pad_i))
        else $error("input delay stage not one cycle");
    output_path_a: assert property (!out_reg_sel_i |-> pad_o == (out_data_i ^ inv_out_i))
        else $error("output bypass or inversion wrong");
    oe_path_a: assert property (config_done_i && !oe_reg_sel_i |-> pad_oe_o == out_enable_i)
        else $error("output enable bypass wrong");
    keeper_level_a: assert property (clk_en_i ##1 keeper_oe_o |-> keeper_o == $past(pad_i))
        else $error("keeper not driving last sensed level");
    pull_choice_a: assert property (config_done_i |-> pull_up_o == (pull_sel_i == pad_cell_pkg::PULL_UP)
        && !(pull_up_o && pull_down_o))
        else $error("pull selection wrong after configuration");
endmodule : pad_cell

//--- tb/pad_board.sv
/* Board side of one pad: resolves the pad wire level.
   Assumes cell outputs come straight from pad_cell. */
`timescale 1ns/1ps
module pad_board (
    // System
    input wire logic mclk_i,
    // Cell side
    input wire logic pad_o,
    input wire logic pad_oe_o,
    input wire logic keeper_o,
    input wire logic keeper_oe_o,
    input wire logic pull_up_o,
    input wire logic pull_down_o,
    // Board driver
    input wire logic board_en_i,
    input wire logic board_val_i,
    output logic pad_i
);
    logic float_reg;
    initial float_reg = 1'h0;
    // Floating wire toggles so a missing driver shows
    always @(posedge mclk_i) float_reg <= !float_reg;
    always_comb begin
        if (pad_oe_o) pad_i = pad_o;
        else if (board_en_i) pad_i = board_val_i;
        else if (keeper_oe_o) pad_i = keeper_o;
        else if (pull_up_o) pad_i = 1'h1;
        else if (pull_down_o) pad_i = 1'h0;
        else pad_i = float_reg;
    end
endmodule : pad_board

//--- tb/pad_cell_test.sv
/* Self-checking bench for pad_cell with a board model.
   Assumes the design files are compiled first. */
`timescale 1ns/1ps
module pad_cell_test;
    logic mclk_i = 1'h0, reset_i = 1'h1, clk_en_i = 1'h1, config_done_i = 1'h0;
    logic pullup_mode_i = 1'h1, out_data_i = 1'h1, out_enable_i = 1'h1, cell_clk_i = 1'h0;
    logic shared_set_reset_i = 1'h0, inv_clk_i = 1'h0, inv_sr_i = 1'h0, inv_out_i = 1'h0;
    logic in_reg_sel_i = 1'h0, in_delay_sel_i = 1'h0, out_reg_sel_i = 1'h0, oe_reg_sel_i = 1'h0;
    logic keeper_sel_i = 1'h1, board_en = 1'h1, board_val = 1'h1;
    logic [2:0] elem_ce_i = 3'h7, latch_sel_i = 3'h0, inv_ce_i = 3'h0;
    pad_cell_pkg::sr_mode_t sr_mode_in_i = pad_cell_pkg::SR_SYNC_SET;
    pad_cell_pkg::sr_mode_t sr_mode_out_i = pad_cell_pkg::SR_SYNC_SET;
    pad_cell_pkg::sr_mode_t sr_mode_oe_i = pad_cell_pkg::SR_SYNC_SET;
    pad_cell_pkg::pull_t pull_sel_i = pad_cell_pkg::PULL_DOWN;
    logic in_data_o, pad_i, pad_o, pad_oe_o, pull_up_o, pull_down_o, keeper_o, keeper_oe_o;
    int err_total = 0;
    int samples_checked = 0;

    always #12.5 mclk_i = !mclk_i;

    pad_cell i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
        .config_done_i(config_done_i), .pullup_mode_i(pullup_mode_i), .out_data_i(out_data_i),
        .out_enable_i(out_enable_i), .in_data_o(in_data_o), .cell_clk_i(cell_clk_i),
        .elem_ce_i(elem_ce_i), .shared_set_reset_i(shared_set_reset_i), .latch_sel_i(latch_sel_i),
        .sr_mode_in_i(sr_mode_in_i), .sr_mode_out_i(sr_mode_out_i), .sr_mode_oe_i(sr_mode_oe_i),
        .inv_clk_i(inv_clk_i), .inv_ce_i(inv_ce_i), .inv_sr_i(inv_sr_i), .inv_out_i(inv_out_i),
        .in_reg_sel_i(in_reg_sel_i), .in_delay_sel_i(in_delay_sel_i), .out_reg_sel_i(out_reg_sel_i),
        .oe_reg_sel_i(oe_reg_sel_i), .keeper_sel_i(keeper_sel_i), .pull_sel_i(pull_sel_i),
        .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o), .pull_up_o(pull_up_o),
        .pull_down_o(pull_down_o), .keeper_o(keeper_o), .keeper_oe_o(keeper_oe_o));

    pad_board i_board (.mclk_i(mclk_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o), .keeper_o(keeper_o),
        .keeper_oe_o(keeper_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
        .board_en_i(board_en), .board_val_i(board_val), .pad_i(pad_i));

    task chk(input string what, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask : chk

    task tally_and_finish;
        if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // Cell clock low-high-low; capture lands at the edge after the rise
    task pulse;
        cell_clk_i <= 1'h1;
        @(posedge mclk_i);
        cell_clk_i <= 1'h0;
        #2;
    endtask : pulse

    initial begin
        #20000;
        err_total++;
        tally_and_finish;
    end

    initial begin
        repeat (5) @(posedge mclk_i);
        reset_i <= 1'h0;
        @(posedge mclk_i);
        #2;
        chk("pad_oe_o", pad_oe_o, 1'h0);
        chk("keeper_oe_o", keeper_oe_o, 1'h0);
        chk("pull_down_o", pull_down_o, 1'h0);
        chk("pull_up_o", pull_up_o, 1'h1);
        @(posedge mclk_i);
        pullup_mode_i <= 1'h0;
        config_done_i <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_i);
            pull_sel_i <= pad_cell_pkg::pull_t'(i);
            #2;
            chk("pull_up_o", pull_up_o, 1'(i == 1));
            chk("pull_down_o", pull_down_o, 1'(i == 2));
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk_i);
            inv_out_i <= 1'(i);
            #2;
            chk("pad_o", pad_o, 1'(i == 0));
            chk("pad_oe_o", pad_oe_o, 1'h1);
        end
        // Keeper holds the last driven level once every driver lets go
        @(posedge mclk_i);
        inv_out_i <= 1'h0;
        @(posedge mclk_i);
        board_en <= 1'h0;
        out_enable_i <= 1'h0;
        repeat (3) @(posedge mclk_i);
        #2;
        chk("keeper_oe_o", keeper_oe_o, 1'h1);
        chk("keeper_o", keeper_o, 1'h1);
        chk("pad_i", pad_i, 1'h1);
        @(posedge mclk_i);
        board_en <= 1'h1;
        board_val <= 1'h0;
        #2;
        chk("in_data_o", in_data_o, 1'h0);
        @(posedge mclk_i);
        {in_reg_sel_i, out_reg_sel_i, oe_reg_sel_i} <= 3'h7;
        board_val <= 1'h1;
        out_enable_i <= 1'h1;
        #2;
        chk("pad_oe_o", pad_oe_o, 1'h0);
        chk("in_data_o", in_data_o, 1'h0);
        @(posedge mclk_i);
        pulse;
        chk("pad_oe_o", pad_oe_o, 1'h1);
        chk("pad_o", pad_o, 1'h1);
        chk("in_data_o", in_data_o, 1'h1);
        // Inverted enables make a high ce inactive
        inv_ce_i <= 3'h7;
        {out_data_i, out_enable_i} <= 2'h0;
        @(posedge mclk_i);
        pulse;
        chk("pad_o", pad_o, 1'h1);
        chk("pad_oe_o", pad_oe_o, 1'h1);
        inv_ce_i <= 3'h0;
        out_enable_i <= 1'h1;
        sr_mode_out_i <= pad_cell_pkg::SR_SYNC_RESET;
        shared_set_reset_i <= 1'h1;
        out_data_i <= 1'h1;
        @(posedge mclk_i);
        pulse;
        chk("pad_o", pad_o, 1'h0);
        sr_mode_out_i <= pad_cell_pkg::SR_ASYNC_PRESET;
        #2;
        chk("pad_o", pad_o, 1'h1);
        @(posedge mclk_i);
        shared_set_reset_i <= 1'h0;
        latch_sel_i <= 3'h2;
        cell_clk_i <= 1'h1;
        out_data_i <= 1'h0;
        #2;
        chk("pad_o", pad_o, 1'h0);
        @(posedge mclk_i);
        cell_clk_i <= 1'h0;
        out_data_i <= 1'h1;
        #2;
        chk("pad_o", pad_o, 1'h0);
        // Closed latch must hold across two mclk_i edges
        in_delay_sel_i <= 1'h1;
        repeat (2) @(posedge mclk_i);
        #2;
        chk("pad_o", pad_o, 1'h0);
        sr_mode_oe_i <= pad_cell_pkg::SR_ASYNC_CLEAR;
        shared_set_reset_i <= 1'h1;
        #2;
        chk("pad_oe_o", pad_oe_o, 1'h0);
        tally_and_finish;
    end
endmodule : pad_cell_test
